// [scinc_pkg.sv]
// Behaviour
// - auto enable feeds calculated increment to subcarrier
// - two hysteresis bits steer increment calculation
// - calculated increment is 26 bits, upper part
// - increment from pixel clock versus reference clock
// - calculated increment readable at 0x21-0x24 only
// - fixed read-only version byte at 0x25
// - six-bit pointer at 0x3F selects register
// - increment nibbles at 0x18 through 0x1F
package scinc_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          CIV_W           = 26;
  localparam int          INC_W           = 32;
  localparam int          SUBCARRIER_INCREMENT_LOW_W      = INC_W - CIV_W;
  // register offsets
  localparam logic [5:0]  OFS_INC_FIRST   = 6'h18;
  localparam logic [5:0]  OFS_INC_LAST    = 6'h1F;
  localparam logic [5:0]  OFS_PLL_CTRL    = 6'h20;
  localparam logic [5:0]  OFS_INC_CTRL    = 6'h21;
  localparam logic [5:0]  OFS_CALC_HIGH   = 6'h22;
  localparam logic [5:0]  OFS_CALC_MID    = 6'h23;
  localparam logic [5:0]  OFS_CALC_LOW    = 6'h24;
  localparam logic [5:0]  OFS_VERSION     = 6'h25;
  localparam logic [5:0]  OFS_POINTER     = 6'h3F;
  // field positions in increment_control
  localparam int          BIT_AUTO_EN     = 0;
  localparam int          BIT_HYST_LO     = 1;
  localparam int          BIT_CALC_LO     = 3;
  // field position in pll control
  localparam int          BIT_CAP_SEL     = 4;
  // values after reset
  localparam logic [2:0]  RST_INC_CTRL    = 3'h1;
  localparam logic [5:0]  RST_PLL_CTRL    = 6'h0A;
  localparam logic [31:0] RST_INCREMENT   = 32'h0000_0000;
  localparam logic [25:0] RST_CALC        = 26'h000_0000;
  localparam logic [5:0]  RST_POINTER     = 6'h00;
endpackage

// [scinc_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module scinc_regs #(
  parameter int         PIX_WIN_LOG2 = 10,
  parameter int         CALC_SHIFT   = 6,
  parameter logic [7:0] VERSION_ID   = 8'h5A   // arbitrary value
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire logic                          pixel_clk_in,
  input  wire logic                          ref_clk_in,
  input  wire logic                          ptr_load_in,
  input  wire logic [scinc_pkg::ADDR_W-1:0]  ptr_data_in,
  input  wire logic                          reg_wr_in,
  input  wire logic [scinc_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                          reg_rd_in,
  output logic      [scinc_pkg::DATA_W-1:0]  reg_rdata_out,
  output logic      [scinc_pkg::INC_W-1:0]   subcarrier_increment_out,
  output logic      [scinc_pkg::CIV_W-1:0]   calculated_increment_out,
  output logic                               auto_increment_enable_out,
  output logic                               loop_filter_cap_sel_out
);
  import scinc_pkg::*;

  generate
    if (PIX_WIN_LOG2 < 1 || PIX_WIN_LOG2 > 20 || CALC_SHIFT < 0 || CALC_SHIFT > 16)
    begin : g_bad
      $error("scinc_regs: window or shift out of range");
    end
  endgenerate

  logic [ADDR_W-1:0]       register_pointer;
  logic [ADDR_W-1:0]       next_register_pointer;
  logic [INC_W-1:0]        subcarrier_increment;
  logic [INC_W-1:0]        next_subcarrier_increment;
  logic [5:0]              pll_ctrl;
  logic [5:0]              next_pll_ctrl;
  logic [2:0]              inc_ctrl;
  logic [2:0]              next_inc_ctrl;
  logic [CIV_W-1:0]        calculated_increment;
  logic [CIV_W-1:0]        next_calculated_increment;
  logic [DATA_W-1:0]       rdata;
  logic [DATA_W-1:0]       next_rdata;
  logic [INC_W-1:0]        inc_out;
  logic [INC_W-1:0]        next_inc_out;
  logic                    pix_prev;
  logic                    ref_prev;
  logic [PIX_WIN_LOG2-1:0] pix_cnt;
  logic [PIX_WIN_LOG2-1:0] next_pix_cnt;
  logic [CIV_W-1:0]        ref_cnt;
  logic [CIV_W-1:0]        next_ref_cnt;

  logic                    pix_rise;
  logic                    ref_rise;
  logic                    win_done;
  logic [CIV_W-1:0]        ref_total;
  logic [CIV_W-1:0]        candidate;
  logic [CIV_W-1:0]        diff;
  logic                    beyond_band;
  logic [2:0]              slot;
  logic                    auto_en;
  logic [1:0]              hysteresis;
  logic [3:0]              slot_nibble;

  assign auto_en    = inc_ctrl[BIT_AUTO_EN];
  assign hysteresis = inc_ctrl[BIT_HYST_LO +: 2];

  // edge counting of both sampled clocks; one window is a fixed number of pixel edges
  assign pix_rise  = pixel_clk_in && !pix_prev;
  assign ref_rise  = ref_clk_in && !ref_prev;
  assign win_done  = pix_rise && (pix_cnt == {PIX_WIN_LOG2{1'b1}});
  assign ref_total = ref_cnt + {{(CIV_W-1){1'b0}}, ref_rise};
  // reference edges per pixel window scale as the increment does, no divider needed
  assign candidate = CIV_W'(ref_total << CALC_SHIFT);
  assign diff      = (candidate > calculated_increment) ? candidate - calculated_increment
                                                        : calculated_increment - candidate;
  // hysteresis band: a new value must differ by more than the setting to be taken
  assign beyond_band = diff > CIV_W'(hysteresis);
  assign slot        = 3'(register_pointer - OFS_INC_FIRST);
  // nibble the pointer selects, used only by the checks below
  assign slot_nibble = subcarrier_increment[(7 - slot) * 4 +: 4];

  // register writes, reads, measurement and output selection
  always_comb
  begin
    next_register_pointer     = register_pointer;
    next_subcarrier_increment = subcarrier_increment;
    next_pll_ctrl             = pll_ctrl;
    next_inc_ctrl             = inc_ctrl;
    next_calculated_increment = calculated_increment;
    next_rdata                = rdata;
    next_pix_cnt              = pix_cnt;
    next_ref_cnt              = ref_total;
    if (pix_rise)
    begin
      next_pix_cnt = pix_cnt + 1'b1;
    end
    // re-measured after every window, not only on request; taken only when beyond the hysteresis band
    if (win_done)
    begin
      next_ref_cnt = '0;
      if (beyond_band)
      begin
        next_calculated_increment = candidate;
      end
    end
    // serial address phase loads the pointer; it takes priority over a data write
    if (ptr_load_in)
    begin
      next_register_pointer = ptr_data_in;
    end
    else if (reg_wr_in)
    begin
      if (register_pointer >= OFS_INC_FIRST && register_pointer <= OFS_INC_LAST)
      begin
        next_subcarrier_increment[(7 - slot) * 4 +: 4] = reg_wdata_in[3:0];
      end
      else if (register_pointer == OFS_PLL_CTRL)
      begin
        next_pll_ctrl = reg_wdata_in[5:0];
      end
      else if (register_pointer == OFS_INC_CTRL)
      begin
        next_inc_ctrl = reg_wdata_in[2:0];  // calculated bits here stay read-only
      end
      else if (register_pointer == OFS_POINTER)
      begin
        next_register_pointer = reg_wdata_in[ADDR_W-1:0];
      end
    end
    // read data: unmapped and reserved bits give zero
    if (reg_rd_in)
    begin
      next_rdata = 8'h00;
      if (register_pointer >= OFS_INC_FIRST && register_pointer <= OFS_INC_LAST)
      begin
        next_rdata[3:0] = subcarrier_increment[(7 - slot) * 4 +: 4];
      end
      else
      begin
        case (register_pointer)
          OFS_PLL_CTRL:  next_rdata[5:0] = pll_ctrl;
          OFS_INC_CTRL:  next_rdata[4:0] = {calculated_increment[25:24], inc_ctrl};
          OFS_CALC_HIGH: next_rdata = calculated_increment[23:16];
          OFS_CALC_MID:  next_rdata = calculated_increment[15:8];
          OFS_CALC_LOW:  next_rdata = calculated_increment[7:0];
          OFS_VERSION:   next_rdata = VERSION_ID;
          OFS_POINTER:   next_rdata[5:0] = register_pointer;
          default:       next_rdata = 8'h00;
        endcase
      end
    end
    // auto mode replaces the upper part only; low bits stay as programmed
    if (auto_en)
    begin
      next_inc_out = {calculated_increment, subcarrier_increment[SUBCARRIER_INCREMENT_LOW_W-1:0]};
    end
    else
    begin
      next_inc_out = subcarrier_increment;
    end
  end

  // pointer resets to zero so control state is defined, though software must not rely on it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      register_pointer     <= RST_POINTER;
      subcarrier_increment <= RST_INCREMENT;
      pll_ctrl             <= RST_PLL_CTRL;
      inc_ctrl             <= RST_INC_CTRL;
      calculated_increment <= RST_CALC;
      rdata                <= 8'h00;
      inc_out              <= RST_INCREMENT;
      pix_prev             <= 1'b0;
      ref_prev             <= 1'b0;
      pix_cnt              <= '0;
      ref_cnt              <= '0;
    end
    else if (ce_in)
    begin
      register_pointer     <= next_register_pointer;
      subcarrier_increment <= next_subcarrier_increment;
      pll_ctrl             <= next_pll_ctrl;
      inc_ctrl             <= next_inc_ctrl;
      calculated_increment <= next_calculated_increment;
      rdata                <= next_rdata;
      inc_out              <= next_inc_out;
      pix_prev             <= pixel_clk_in;
      ref_prev             <= ref_clk_in;
      pix_cnt              <= next_pix_cnt;
      ref_cnt              <= next_ref_cnt;
    end
  end

  assign reg_rdata_out             = rdata;
  assign subcarrier_increment_out  = inc_out;
  assign calculated_increment_out  = calculated_increment;
  assign auto_increment_enable_out = auto_en;
  assign loop_filter_cap_sel_out   = pll_ctrl[BIT_CAP_SEL];

  // checks on the outputs against their causes
  a_ptr_load: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && ptr_load_in |=> register_pointer == $past(ptr_data_in))
    else $error("pointer not loaded");
  a_version_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_VERSION |=> reg_rdata_out == VERSION_ID)
    else $error("version byte wrong");
  a_calc_ro_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_INC_CTRL
    |=> reg_rdata_out[4:3] == $past(calculated_increment[25:24]))
    else $error("calculated top bits misread");
  a_auto_upper: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && auto_en |=> subcarrier_increment_out[31:6] == $past(calculated_increment))
    else $error("auto increment not applied");
  a_manual_inc: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !auto_en |=> subcarrier_increment_out == $past(subcarrier_increment))
    else $error("programmed increment not applied");
  a_calc_window: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !win_done |=> $stable(calculated_increment))
    else $error("calculated value moved outside a window end");
  a_hyst_band: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && win_done && diff <= CIV_W'(hysteresis) |=> $stable(calculated_increment))
    else $error("change inside hysteresis band taken");
  a_clock_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
    !ce_in |=> $stable(register_pointer) && $stable(pix_cnt) && $stable(reg_rdata_out))
    else $error("state moved while frozen");
  a_calc_update: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && win_done && beyond_band |=> calculated_increment_out == $past(candidate))
    else $error("new measurement not taken");

  // data writes land in the register the pointer selects
  a_wr_nibble: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !ptr_load_in && reg_wr_in && register_pointer >= OFS_INC_FIRST
    && register_pointer <= OFS_INC_LAST |=> slot_nibble == $past(reg_wdata_in[3:0]))
    else $error("increment nibble not written");
  a_wr_pll: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !ptr_load_in && reg_wr_in && register_pointer == OFS_PLL_CTRL
    |=> pll_ctrl == $past(reg_wdata_in[5:0]))
    else $error("pll control not written");
  a_wr_inc_ctrl: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !ptr_load_in && reg_wr_in && register_pointer == OFS_INC_CTRL
    |=> inc_ctrl == $past(reg_wdata_in[2:0]))
    else $error("increment control not written");
  a_wr_pointer: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !ptr_load_in && reg_wr_in && register_pointer == OFS_POINTER
    |=> register_pointer == $past(reg_wdata_in[ADDR_W-1:0]))
    else $error("pointer not written");
  // read-only places must not disturb writable state
  a_ro_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_wr_in && register_pointer >= OFS_CALC_HIGH && register_pointer <= OFS_VERSION
    |=> $stable(subcarrier_increment) && $stable(pll_ctrl) && $stable(inc_ctrl))
    else $error("read-only write changed state");

  // read data of each mapped place except pll control and version, one cycle after the strobe
  a_calc_high_rd: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_CALC_HIGH
    |=> reg_rdata_out == $past(calculated_increment[23:16]))
    else $error("calculated high byte misread");
  a_calc_mid_rd: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_CALC_MID
    |=> reg_rdata_out == $past(calculated_increment[15:8]))
    else $error("calculated mid byte misread");
  a_calc_low_rd: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_CALC_LOW
    |=> reg_rdata_out == $past(calculated_increment[7:0]))
    else $error("calculated low byte misread");
  a_ptr_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_POINTER
    |=> reg_rdata_out == {2'b00, $past(register_pointer)})
    else $error("pointer misread");
  a_nibble_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer >= OFS_INC_FIRST && register_pointer <= OFS_INC_LAST
    |=> reg_rdata_out == {4'h0, $past(slot_nibble)})
    else $error("increment nibble misread");
  a_ctrl_read: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && register_pointer == OFS_INC_CTRL
    |=> reg_rdata_out[2:0] == $past(inc_ctrl) && reg_rdata_out[7:5] == 3'h0)
    else $error("increment control misread");
  // unmapped places read as zero so a host scan sees nothing stray
  a_unmapped_rd: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && (register_pointer < OFS_INC_FIRST
    || (register_pointer > OFS_VERSION && register_pointer != OFS_POINTER))
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");

  // measurement counters: one window is a fixed count of pixel rises
  a_pix_count: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && pix_rise |=> pix_cnt == $past(pix_cnt) + 1'b1)
    else $error("pixel rise not counted");
  a_pix_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !pix_rise |=> $stable(pix_cnt))
    else $error("pixel count moved without a rise");
  a_ref_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && win_done |=> ref_cnt == '0)
    else $error("reference count not cleared");
  a_ref_count: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !win_done |=> ref_cnt == $past(ref_total))
    else $error("reference rise not counted");
  // programmed low bits survive in auto mode
  a_auto_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && auto_en |=> subcarrier_increment_out[5:0] == $past(subcarrier_increment[5:0]))
    else $error("programmed low bits lost");
endmodule
`default_nettype wire

// [scinc_dummy_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [scinc_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host model: pointer phase, then one data phase, changed on falling edges
module scinc_host (
  input  wire logic       clk_in,
  output logic            ptr_load_out,
  output logic      [5:0] ptr_data_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_rd_out
);
  initial
  begin
    {ptr_load_out, reg_wr_out, reg_rd_out} = 3'h0;
    ptr_data_out  = 6'h00;
    reg_wdata_out = 8'h00;
  end
  // idle lines show inverted values so a stale byte never matches by luck
  task automatic access(input logic [5:0] a, input logic wr, input logic [7:0] d);
    @(negedge clk_in);
    ptr_load_out  = 1'h1;
    ptr_data_out  = a;
    reg_wdata_out = ~d;
    @(negedge clk_in);
    ptr_load_out  = 1'h0;
    ptr_data_out  = ~a;
    {reg_wr_out, reg_rd_out, reg_wdata_out} = {wr, ~wr, d};
    @(negedge clk_in);
    {reg_wr_out, reg_rd_out, reg_wdata_out} = {2'h0, ~d};
  endtask
endmodule
`default_nettype wire

// [tb_subcarrier_increment_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_subcarrier_increment_regs;
  import scinc_pkg::*;
  localparam logic [7:0]  VERSION = 8'hC3;         // arbitrary value
  localparam logic [26:0] CAP_BY_MODE = 27'h6D0EED7;
  logic clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, pix = 1'h0, refc = 1'h0;
  logic ld, wr, rd, rd_seen = 1'h0, auto_en, cap_sel;
  logic [5:0] pd;
  logic [7:0] wd, rdata, lfsr = 8'h37;
  logic [25:0] calc;
  logic [31:0] sub_inc, prog = 32'h0;
  logic [7:0] expect_q[$];
  int mismatches = 0, n_compared = 0, cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  scinc_regs #(.PIX_WIN_LOG2(3), .VERSION_ID(VERSION)) dut (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(ce_in), .pixel_clk_in(pix), .ref_clk_in(refc),
    .ptr_load_in(ld), .ptr_data_in(pd), .reg_wr_in(wr), .reg_wdata_in(wd),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .subcarrier_increment_out(sub_inc),
    .calculated_increment_out(calc), .auto_increment_enable_out(auto_en),
    .loop_filter_cap_sel_out(cap_sel));
  scinc_host host (.clk_in(clk_in), .ptr_load_out(ld), .ptr_data_out(pd),
    .reg_wr_out(wr), .reg_wdata_out(wd), .reg_rd_out(rd));
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // read requests note the expected byte; the watcher below compares it
  task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
    expect_q.push_back(e);
    host.access(a, 1'h0, 8'h00);
  endtask
  // pixel rises per window, with n reference rises after each but the last
  task automatic window(input int n);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_in) pix = 1'h1;
      repeat (2) @(negedge clk_in);
      pix = 1'h0;
      for (int k = 0; k < ((i < 7) ? n : 0); k++)
      begin
        @(negedge clk_in) refc = 1'h1;
        @(negedge clk_in) refc = 1'h0;
      end
      @(negedge clk_in);
    end
    repeat (4) @(negedge clk_in);
  endtask
  // read data lands one cycle after the taken strobe
  always @(posedge clk_in) rd_seen <= rd && ce_in && !rst_in;
  always @(negedge clk_in)
    if (rd_seen && expect_q.size() > 0)
      check(32'(rdata), 32'(expect_q.pop_front()));
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'h0;
    check(32'(auto_en), 32'h1);
    rd_exp(OFS_VERSION, VERSION);
    rd_exp(OFS_INC_CTRL, 8'h01);
    rd_exp(OFS_PLL_CTRL, 8'h0A);
    // read-only places and an unmapped one must shrug off random writes
    for (int a = 34; a <= 48; a += (a == 37) ? 11 : 1)
    begin
      lfsr = next_rand(lfsr);
      host.access(6'(a), 1'h1, lfsr);
      rd_exp(6'(a), (a == 37) ? VERSION : 8'h00);
    end
    host.access(OFS_INC_CTRL, 1'h1, 8'h1E);
    rd_exp(OFS_INC_CTRL, 8'h06);
    rd_exp(OFS_POINTER, 8'h3F);
    for (int i = 0; i < 8; i++)
    begin
      lfsr = next_rand(lfsr);
      host.access(OFS_INC_FIRST + 6'(i), 1'h1, lfsr);
      prog = {prog[27:0], lfsr[3:0]};
    end
    repeat (2) @(negedge clk_in);
    check(sub_inc, prog);
    for (int m = 0; m <= 26; m++)
    begin
      host.access(OFS_PLL_CTRL, 1'h1, {3'h0, CAP_BY_MODE[m], 4'hA});
      repeat (2) @(negedge clk_in);
      check(32'(cap_sel), 32'(CAP_BY_MODE[m]));
    end
    ce_in = 1'h0;
    host.access(OFS_INC_CTRL, 1'h1, 8'h01);
    ce_in = 1'h1;
    check(32'(auto_en), 32'h0);
    host.access(OFS_INC_CTRL, 1'h1, 8'h01);
    window(3);
    check(32'(calc), 32'h540);
    check(sub_inc, {26'h540, prog[5:0]});
    rd_exp(OFS_CALC_LOW, 8'h40);
    rd_exp(OFS_CALC_MID, 8'h05);
    rd_exp(OFS_CALC_HIGH, 8'h00);
    window(2);
    check(32'(calc), 32'h380);
    check(sub_inc, {26'h380, prog[5:0]});
    host.access(OFS_INC_CTRL, 1'h1, 8'h07);
    window(2);
    check(32'(calc), 32'h380);
    host.access(OFS_INC_CTRL, 1'h1, 8'h00);
    repeat (3) @(negedge clk_in);
    check(sub_inc, prog);
    repeat (3) @(negedge clk_in);
    complete_run();
  end
endmodule
`default_nettype wire
